//--- hw/pot_pkg.sv
// Package for the prescaled overflow timer: register map, field positions,
// reset values, bus phase encoding and shared helper functions.
// Assumes a 32-bit AHB-Lite register bus and one system clock.

package pot_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets (one aligned word each)
  // ------------------------------------------------------------------
  localparam logic [7:0] POT_CTRL_OFF = 8'h00;    // counter_control
  localparam logic [7:0] POT_COUNT_OFF = 8'h04;   // count_value / preload
  localparam logic [7:0] POT_STATUS_OFF = 8'h08;  // Sticky flags, write one to clear
  localparam logic [7:0] POT_MASK_OFF = 8'h0c;    // Interrupt enable, same layout
  localparam logic [7:0] POT_SET_OFF = 8'h10;     // Write one to set a flag

  // ------------------------------------------------------------------
  // Field positions and widths
  // ------------------------------------------------------------------
  localparam int unsigned POT_SRC_BIT = 5;        // clock_source_select
  localparam int unsigned POT_RUN_BIT = 4;        // count_run_enable
  localparam int unsigned POT_PSC_LSB = 0;        // prescale_ratio_select
  localparam int unsigned POT_PSC_W = 3;
  localparam int unsigned POT_OVF_BIT = 0;        // Overflow flag in status/mask/set

  // ------------------------------------------------------------------
  // Reset values and counts
  // ------------------------------------------------------------------
  localparam logic [7:0] POT_CTRL_RESET = 8'h00;
  localparam logic [7:0] POT_COUNT_RESET = 8'h00; // Undefined to software
  localparam logic [7:0] POT_COUNT_FULL = 8'hff;
  localparam int unsigned POT_DIV_W = 7;          // Divide by up to 128

  // ------------------------------------------------------------------
  // Bus data phase, one-hot
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_WRITE = 3'b010,
    PH_READ = 3'b100
  } pot_phase_e;

  // Low bits of the divider that must all be set for a divided pulse
  function automatic logic [POT_DIV_W-1:0] pot_ratio_mask(input logic [POT_PSC_W-1:0] sel);
    logic [POT_DIV_W:0] one_hot;
    one_hot = (POT_DIV_W+1)'(1) << sel;
    return POT_DIV_W'(one_hot - (POT_DIV_W+1)'(1));
  endfunction

endpackage

//--- hw/pot_prescaler.sv
// Prescaler of the overflow timer: divides a source pulse train by 2**sel.
// Assumes src_tick is a one-cycle enable in the hclk domain.
`timescale 1ns/10ps

module pot_prescaler
  import pot_pkg::*;
#(
  parameter int unsigned DIV_W = POT_DIV_W
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic enable,
  input wire logic [POT_PSC_W-1:0] sel,
  input wire logic src_tick,
  // Divided pulse
  output logic tick_out
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [DIV_W-1:0] div;  // Source pulses seen
  } pot_psc_s;

  pot_psc_s psc_reg;
  pot_psc_s psc_next;
  logic [DIV_W-1:0] mask;

  // Pulse when the low sel bits are all ones on a source pulse [RULE_02]
  always_comb begin
    mask = DIV_W'(pot_ratio_mask(sel));
    psc_next = psc_reg;
    tick_out = enable && src_tick && ((psc_reg.div & mask) == mask);
    if (!enable) begin
      // Restart the ratio cleanly on each run
      psc_next.div = '0;
    end else if (src_tick) begin
      psc_next.div = psc_reg.div + DIV_W'(1);
    end
  end

  // Register the state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      psc_reg <= '0;
    end else begin
      psc_reg <= psc_next;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  chk_psc_ratio: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_02]
    tick_out |-> (src_tick && ((psc_reg.div & mask) == mask)))
    else $error("prescaler pulse outside its ratio");

  // Above ratio one a pulse leaves the lowest divider bit clear next cycle
  chk_psc_spacing: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE_02]
    tick_out |=> (!tick_out || (sel == 3'h0)))
    else $error("prescaler pulses too close together");

endmodule

//--- hw/pot_timer.sv
// Prescaled overflow timer with AHB-Lite register slave and interrupt.
// Assumes one 40 MHz hclk; low_speed_clock is a slow level sampled here.
//
// Overview of operation
// RULE_01: Bit 5 selects main or low-speed source
// RULE_02: Three-bit field divides by 1 to 128
// RULE_03: Count rises by one per divided pulse
// RULE_04: Overflow past full flags, reloads, keeps counting
// RULE_05: Stopped: preload write also loads the count
// RULE_06: Running: preload write waits for next overflow
// RULE_07: Bit 4 runs counter; clear holds count
// RULE_08: Bits 7,6,3 read zero; fields reset zero
// RULE_09: Count read or preload write blocks ticking
// RULE_10: Overflow sets flag; interrupt needs enable too
// RULE_11: Overflow wakes power-down regardless of enable
// RULE_12: Software presets flag to avoid wake-up
// RULE_13: Software loads count before first enable
// RULE_14: Count read returns running count, not preload
// RULE_15: Flag sticky until cleared; slow source synchronised
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps

module pot_timer
  import pot_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Timer environment
  input wire logic low_speed_clock,
  input wire logic power_down,
  // Events
  output logic irq,
  output logic wake_req
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    pot_phase_e phase;     // Bus data phase in progress
    logic [7:0] addr;      // Offset latched in address phase
    logic [31:0] rdata;    // Read data, set up in address phase
    logic src_sel;         // clock_source_select
    logic run;             // count_run_enable
    logic [2:0] psc;       // prescale_ratio_select
    logic [7:0] count;     // Running count
    logic [7:0] preload;   // Reload value
    logic ovf_flag;        // Sticky overflow request
    logic ovf_mask;        // Interrupt enable
    logic [2:0] sub_sync;  // Slow clock sync pair plus edge history
    logic wake;            // One-cycle wake-up pulse
  } pot_state_s;

  pot_state_s r;           // Registered state
  pot_state_s n;           // Next state
  logic acc;               // Address phase taken this cycle
  logic src_tick;          // Prescaler input pulse
  logic psc_tick;          // Divided pulse
  logic inhibit;           // Counter clock suppressed
  logic cnt_tick;          // Pulse that really advances the count
  logic ovf_ev;            // Overflow this cycle
  logic sub_edge;          // Rising edge of the slow source

  // Read view of a register; unmapped offsets read zero
  function automatic logic [31:0] read_mux(input logic [7:0] a, input pot_state_s s);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      POT_CTRL_OFF: begin
        // Bits 7, 6 and 3 stay zero [RULE_08]
        v[POT_SRC_BIT] = s.src_sel;
        v[POT_RUN_BIT] = s.run;
        v[POT_PSC_LSB +: POT_PSC_W] = s.psc;
      end
      POT_COUNT_OFF: begin
        // Live count, never the preload [RULE_14]
        v[7:0] = s.count;
      end
      POT_STATUS_OFF: begin
        v[POT_OVF_BIT] = s.ovf_flag;
      end
      POT_MASK_OFF: begin
        v[POT_OVF_BIT] = s.ovf_mask;
      end
      default: begin
        v = 32'h0000_0000;
      end
    endcase
    return v;
  endfunction

  // ------------------------------------------------------------------
  // Clock source and prescaler
  // ------------------------------------------------------------------

  // Edge seen between second sync stage and its history [RULE_15]
  assign sub_edge = r.sub_sync[1] && !r.sub_sync[2];

  // Main clock ticks every cycle, slow source once per rising edge [RULE_01]
  assign src_tick = r.src_sel ? sub_edge : 1'b1;

  // Divider between source and counter
  pot_prescaler #(
    .DIV_W(POT_DIV_W)
  ) u_prescaler (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(r.run),
    .sel(r.psc),
    .src_tick(src_tick),
    .tick_out(psc_tick)
  );

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------

  // Only single word transfers come; hsize needs no decode
  assign acc = hsel && hready && htrans[1];

  // Clock held off while the count is read or the preload written [RULE_09]
  // One divided pulse may be lost here; that is accepted behaviour.
  assign inhibit = (acc && !hwrite && (haddr[7:0] == POT_COUNT_OFF))
                   || ((r.phase == PH_WRITE) && (r.addr == POT_COUNT_OFF));

  assign cnt_tick = r.run && psc_tick && !inhibit;  // [RULE_03] [RULE_07]
  assign ovf_ev = cnt_tick && (r.count == POT_COUNT_FULL);

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    n = r;
    n.wake = 1'b0;
    // Slow source enters through two flops
    n.sub_sync = {r.sub_sync[1], r.sub_sync[0], low_speed_clock};

    // Address phase: latch target, prepare read data
    if (acc) begin
      n.addr = haddr[7:0];
      if (hwrite) begin
        n.phase = PH_WRITE;
      end else begin
        n.phase = PH_READ;
        n.rdata = read_mux(haddr[7:0], r);
      end
    end else begin
      n.phase = PH_IDLE;
    end

    // Data phase of a write
    if (r.phase == PH_WRITE) begin
      unique case (r.addr)
        POT_CTRL_OFF: begin
          n.src_sel = hwdata[POT_SRC_BIT];
          n.run = hwdata[POT_RUN_BIT];
          n.psc = hwdata[POT_PSC_LSB +: POT_PSC_W];
        end
        POT_COUNT_OFF: begin
          n.preload = hwdata[7:0];          // [RULE_06]
          if (!r.run) begin
            n.count = hwdata[7:0];          // [RULE_05]
          end
        end
        POT_STATUS_OFF: begin
          if (hwdata[POT_OVF_BIT]) begin
            n.ovf_flag = 1'b0;
          end
        end
        POT_MASK_OFF: begin
          n.ovf_mask = hwdata[POT_OVF_BIT];
        end
        POT_SET_OFF: begin
          // Lets software mask the wake-up before halting
          if (hwdata[POT_OVF_BIT]) begin
            n.ovf_flag = 1'b1;
          end
        end
        default: begin
          // Unmapped write is ignored
        end
      endcase
    end

    // Counting; a count write never coincides since it inhibits
    if (cnt_tick) begin
      if (r.count == POT_COUNT_FULL) begin
        n.count = r.preload;                // [RULE_04]
      end else begin
        n.count = r.count + 8'h01;          // [RULE_03]
      end
    end

    // Overflow event; set after the clear so the set wins [RULE_10] [RULE_15]
    if (ovf_ev) begin
      n.ovf_flag = 1'b1;
      // Wake in power-down unless the flag was already pending [RULE_11]
      n.wake = power_down && !r.ovf_flag;
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r.phase <= PH_IDLE;
      r.addr <= 8'h00;
      r.rdata <= 32'h0000_0000;
      r.src_sel <= POT_CTRL_RESET[POT_SRC_BIT];  // [RULE_08]
      r.run <= POT_CTRL_RESET[POT_RUN_BIT];
      r.psc <= POT_CTRL_RESET[POT_PSC_LSB +: POT_PSC_W];
      r.count <= POT_COUNT_RESET;
      r.preload <= POT_COUNT_RESET;
      r.ovf_flag <= 1'b0;
      r.ovf_mask <= 1'b0;
      r.sub_sync <= 3'h0;
      r.wake <= 1'b0;
    end else begin
      r <= n;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign hreadyout = 1'b1;                  // Zero wait states
  assign hresp = 1'b0;                      // Always OKAY
  assign hrdata = r.rdata;
  assign irq = r.ovf_flag && r.ovf_mask;    // [RULE_10]
  assign wake_req = r.wake;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_count_write;
    (r.phase == PH_WRITE) && (r.addr == POT_COUNT_OFF);
  endsequence

  sequence s_count_read;
    acc && !hwrite && (haddr[7:0] == POT_COUNT_OFF);
  endsequence

  sequence s_main_free_run;
    r.run && !r.src_sel && (r.psc == 3'h0) && !inhibit && (r.phase != PH_WRITE);
  endsequence

  chk_main_increment: assert property ( // [RULE_01]
    s_main_free_run ##0 (r.count != POT_COUNT_FULL) |=> (r.count == $past(r.count) + 8'h01))
    else $error("main clock at ratio one did not count");

  chk_sub_hold: assert property ( // [RULE_15]
    (r.src_sel && !sub_edge && (r.phase != PH_WRITE)) |=> $stable(r.count))
    else $error("count moved without a slow source edge");

  chk_overflow_reload: assert property ( // [RULE_04]
    ovf_ev |=> (r.count == $past(r.preload)) && r.ovf_flag)
    else $error("overflow did not reload and flag");

  chk_off_load: assert property ( // [RULE_05]
    s_count_write ##0 !r.run |=> (r.count == $past(hwdata[7:0])))
    else $error("stopped counter missed the preload write");

  chk_on_preload: assert property ( // [RULE_06]
    s_count_write ##0 r.run |=> $stable(r.count) && (r.preload == $past(hwdata[7:0])))
    else $error("running counter took preload early");

  chk_run_hold: assert property ( // [RULE_07]
    (!r.run && (r.phase != PH_WRITE)) [*2] |-> $stable(r.count))
    else $error("count changed while stopped");

  chk_ctrl_zero: assert property ( // [RULE_08]
    (acc && !hwrite && (haddr[7:0] == POT_CTRL_OFF)) |=>
      (hrdata[31:6] == 26'h0) && !hrdata[3])
    else $error("unimplemented control bits read non-zero");

  // A stopped counter's own load in a pipelined write data phase is not a tick
  chk_read_count: assert property ( // [RULE_14] [RULE_09]
    s_count_read ##0 !((r.phase == PH_WRITE) && (r.addr == POT_COUNT_OFF))
      |=> (hrdata[7:0] == $past(r.count)) ##0 $stable(r.count))
    else $error("count read wrong or clock not suppressed");

  chk_irq_follow: assert property ( // [RULE_10]
    (ovf_ev && r.ovf_mask && !(r.phase == PH_WRITE && r.addr == POT_MASK_OFF)) |=> irq)
    else $error("enabled overflow raised no interrupt");

  chk_wake_pulse: assert property ( // [RULE_11]
    (ovf_ev && power_down && !r.ovf_flag) |=> wake_req ##1 !wake_req)
    else $error("power-down overflow gave no single wake pulse");

  chk_flag_sticky: assert property ( // [RULE_15]
    (r.ovf_flag && !(r.phase == PH_WRITE && r.addr == POT_STATUS_OFF)) |=> r.ovf_flag)
    else $error("overflow flag dropped without a clear");

endmodule

//--- dv/pot_tb.sv
// Self-checking bench of the prescaled overflow timer over AHB-Lite.
// Assumes a zero-wait-state slave and one 40 MHz clock; the bench drives every input but hready, which takes hreadyout.
`timescale 1ns/10ps

module testbench
  import pot_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  // Bus master side
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  // Timer environment
  logic low_speed_clock = 1'b0;
  logic power_down = 1'b0;
  // Observed outputs
  logic hreadyout;
  logic hresp;
  logic irq;
  logic wake_req;
  logic [31:0] hrdata;
  // Bench state
  logic rd_phase = 1'b0; // Read data phase in flight
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  logic [31:0] rng = 32'h000136a4;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int wakes = 0;
  int slow_div = 0;

  // 25 ns period
  always #12.5 hclk = ~hclk;

  // Single slave, so its ready is the bus ready
  pot_timer dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .low_speed_clock(low_speed_clock), .power_down(power_down),
    .irq(irq), .wake_req(wake_req)
  );

  // Cycle count, wake pulse count, slow source of 10 cycles period
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (wake_req === 1'b1) begin
      wakes <= wakes + 1;
    end
    slow_div <= (slow_div == 4) ? 0 : slow_div + 1;
    if (slow_div == 4) begin
      low_speed_clock <= ~low_speed_clock;
    end
  end

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Read results are taken off the queue at the data phase edge
  always @(posedge hclk) begin
    if (rd_phase && hreadyout === 1'b1) begin
      check("hresp", {31'h0, hresp}, 32'h0);
      if (exp_q.size() == 0) begin
        check("read_queue", 32'h1, 32'h0);
      end else begin
        check("hrdata", hrdata, exp_q.pop_front());
      end
    end
  end

  // One single transfer; waits on ready, the watchdog cuts a hang
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_phase <= ~wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_phase <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  // Note first, so the monitor finds it at the data edge
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Waits for the interrupt, returns the cycle it was seen in
  task automatic wait_irq(output int t);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (irq !== 1'b1 && n < 3000);
    check("irq_seen", {31'h0, irq}, 32'h1);
    t = cyc;
  endtask

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Whole run is near 4800 cycles
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    $display("mismatch watchdog expected finish seen timeout");
    final_report();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    int t0;
    int t1;
    logic [31:0] v;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, unused bits, unmapped place
    rd(POT_CTRL_OFF, 32'h0);
    wr(POT_CTRL_OFF, 32'hff);
    rd(POT_CTRL_OFF, 32'h37);
    rd(8'h20, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      // Run bit kept clear, so the count follows each write
      wr(POT_CTRL_OFF, v & 32'hef);
      rd(POT_CTRL_OFF, v & 32'h27);
      wr(POT_COUNT_OFF, {24'h0, v[15:8]});
      rd(POT_COUNT_OFF, {24'h0, v[15:8]});
    end
    $display("test registers done");
    // Overflow period per ratio; index 8 is the slow source undivided
    wr(POT_MASK_OFF, 32'h1);
    for (int p = 0; p < 9; p++) begin
      wr(POT_CTRL_OFF, 32'h0);
      wr(POT_COUNT_OFF, 32'hfc);
      wr(POT_STATUS_OFF, 32'h1);
      wr(POT_CTRL_OFF, (p == 8) ? 32'h30 : 32'h10 | p);
      wait_irq(t0);
      wr(POT_STATUS_OFF, 32'h1);
      wait_irq(t1);
      check("period", 32'(t1 - t0), (p == 8) ? 32'h28 : 32'h4 << p);
    end
    $display("test periods done");
    // Flag stays set while stopped and masked
    wr(POT_CTRL_OFF, 32'h0);
    wr(POT_MASK_OFF, 32'h0);
    idle(2);
    check("irq_masked", {31'h0, irq}, 32'h0);
    rd(POT_STATUS_OFF, 32'h1);
    wr(POT_MASK_OFF, 32'h1);
    idle(1);
    check("irq_on", {31'h0, irq}, 32'h1);
    wr(POT_STATUS_OFF, 32'h1);
    idle(1);
    check("irq_off", {31'h0, irq}, 32'h0);
    rd(POT_STATUS_OFF, 32'h0);
    wr(POT_SET_OFF, 32'h1);
    rd(POT_STATUS_OFF, 32'h1);
    $display("test interrupt done");
    // Reads two cycles apart each lose the tick of their address cycle
    wr(POT_CTRL_OFF, 32'h0);
    wr(POT_COUNT_OFF, 32'h10);
    wr(POT_CTRL_OFF, 32'h10);
    rd(POT_COUNT_OFF, 32'h10);
    rd(POT_COUNT_OFF, 32'h11);
    rd(POT_COUNT_OFF, 32'h12);
    wr(POT_CTRL_OFF, 32'h0);
    $display("test inhibit done");
    // Preload while running waits for the overflow; stop holds the count
    wr(POT_STATUS_OFF, 32'h1);
    wr(POT_COUNT_OFF, 32'hf0);
    wr(POT_CTRL_OFF, 32'h17);
    wr(POT_COUNT_OFF, 32'h80);
    rd(POT_COUNT_OFF, 32'hf0);
    wait_irq(t0);
    // Stop lands well before the next tick at ratio 128
    wr(POT_CTRL_OFF, 32'h07);
    idle(300);
    rd(POT_COUNT_OFF, 32'h80);
    $display("test reload done");
    // Wake-up in power-down, interrupt masked
    wr(POT_STATUS_OFF, 32'h1);
    wr(POT_MASK_OFF, 32'h0);
    power_down <= 1'b1;
    wr(POT_COUNT_OFF, 32'hfc);
    t0 = wakes;
    wr(POT_CTRL_OFF, 32'h10);
    idle(30);
    check("wake_pulses", 32'(wakes - t0), 32'h1);
    wr(POT_CTRL_OFF, 32'h0);
    // Preset flag: software's way to stay asleep
    wr(POT_SET_OFF, 32'h1);
    wr(POT_COUNT_OFF, 32'hfc);
    t0 = wakes;
    wr(POT_CTRL_OFF, 32'h10);
    idle(30);
    check("wake_blocked", 32'(wakes - t0), 32'h0);
    power_down <= 1'b0;
    wr(POT_STATUS_OFF, 32'h1);
    t0 = wakes;
    idle(30);
    check("wake_awake", 32'(wakes - t0), 32'h0);
    $display("test wake done");
    final_report();
  end
endmodule
